// ### rtl/wdt_reset_defines.svh
// Constants for the watchdog and reset source block
// Overview of operation
// - Overflow action selectable once; reset default
// - Overflow: reset if select 1, else interrupt
// - Overflow rise activates output unless cleared
// - Counter holds in stop and idle
// - Enable at bit 3, reset value 1
// - Two-bit detection time, fc or fs
// - First control register is write-only
// - 4E clears, B1 disables, others ignored
// - Disable code works only with enable 0
// - Counter cleared while being disabled
// - Interrupt ignores individual enable register
// - New interrupt waits for return-from-nmi
// - Watchdog reset drives pin low 12/fc
// - Watchdog reset in slow mode starts oscillator
// - External reset held three machine cycles
// - Reset release starts from vector FFFE/FFFF
// - Fetch from 0040-023F causes trap reset
// - Both oscillator enables 0 causes reset
// - Reset initialises core flags, watchdog enabled
`ifndef WDT_RESET_DEFINES_SVH
`define WDT_RESET_DEFINES_SVH
`define ADDR_CONTROL_ONE   8'h34
`define ADDR_CODE_WRITE    8'h35
`define CONTROL_ONE_RESET  8'h09
`define ENABLE_BIT         3
`define TIME_LSB           1
`define TIME_MSB           2
`define ACTION_BIT         0
`define CODE_CLEAR         8'h4E
`define CODE_DISABLE       8'hB1
`define TRAP_LOW           16'h0040
`define TRAP_HIGH          16'h023F
`define VECTOR_LOW         16'hFFFE
`define VECTOR_HIGH        16'hFFFF
`define HIGH_OSC_BIT       7
`define LOW_OSC_BIT        6
`define RESET_TIME_FC      12
`define FC_PER_CLOCK       1
`define RESET_CYCLES       (`RESET_TIME_FC / `FC_PER_CLOCK)
`define EXT_MIN_CYCLES     (`RESET_TIME_FC / `FC_PER_CLOCK)
`define COUNT_WIDTH        25
`define PULSE_WIDTH        4
`endif

// ### rtl/wdt_reset_pkg.sv
// Types for the watchdog and reset source block
package wdt_reset_pkg;
    typedef struct packed {
        logic       write_strobe;
        logic [7:0] address;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        logic stop_mode;
        logic idle_mode;
        logic slow_mode;
        logic fs_tick;
    } power_mode_t;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_WATCHDOG,
        SRC_TRAP,
        SRC_CLOCK
    } reset_source_t;
endpackage : wdt_reset_pkg

// ### rtl/wdt_reset_top.sv
// Watchdog timer with on-chip reset generation and reset pin control
`timescale 1ns/100ps
`include "wdt_reset_defines.svh"
module wdt_reset_top (
    input  wire logic                       CLOCK,
    input  wire logic                       RST,
    input  wire wdt_reset_pkg::reg_write_t  REG_WRITE,
    input  wire wdt_reset_pkg::power_mode_t POWER_MODE,
    input  wire logic                       FETCH_VALID,
    input  wire logic [15:0]                FETCH_ADDR,
    input  wire logic [7:0]                 SYSTEM_CONTROL_TWO,
    input  wire logic                       RETURN_FROM_NMI,
    input  wire logic                       RESET_PIN_IN,
    output logic                            RESET_PIN_OUT,
    output logic                            RESET_PIN_OE,
    output logic                            WATCHDOG_INTERRUPT,
    output logic                            SYSTEM_RESET,
    output logic                            HIGH_OSC_ON_REQ,
    output logic [15:0]                     VECTOR_ADDR,
    output logic [1:0]                      RESET_CAUSE
);
    import wdt_reset_pkg::*;

    typedef struct packed {
        logic [7:0]            control_one;
        logic                  action_locked;
        logic                  disabled;
        logic [24:0]           count;
        logic                  wrapped;
        logic                  nmi_pending;
        logic                  nmi_in_service;
        logic                  int_out;
        logic [`PULSE_WIDTH-1:0] pulse_count;
        logic                  pin_drive;
        logic [`PULSE_WIDTH-1:0] ext_low_count;
        logic                  sys_reset;
        logic                  osc_req;
        reset_source_t         cause;
        logic                  pin_out;
        logic [15:0]           vector;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic       wr_one;
    logic       wr_two;
    logic       tick;
    logic       wrap_ready;
    logic       trap_hit;
    logic       clock_stop;
    logic [7:0] wdata;

    assign wdata  = REG_WRITE.data;
    assign wr_one = REG_WRITE.write_strobe
                    && REG_WRITE.address == `ADDR_CONTROL_ONE;
    assign wr_two = REG_WRITE.write_strobe
                    && REG_WRITE.address == `ADDR_CODE_WRITE;

    // Slow mode counts fs ticks; the fs period equals 2^8 fc so the
    // shorter tap offsets are the fc ones minus eight.
    assign tick = POWER_MODE.slow_mode ? POWER_MODE.fs_tick : 1'b1;

    // Tap pick: 2^25, 2^23, 2^21, 2^19 of fc; 2^17 down to 2^11 of fs.
    // The event is the carry out of the low bits, so it recurs once per
    // detection interval and the block doubles as an interval timer.
    always_comb begin
        case (state_reg.control_one[`TIME_MSB:`TIME_LSB])
            2'h0: wrap_ready = POWER_MODE.slow_mode
                               ? &state_reg.count[16:0]
                               : &state_reg.count[24:0];
            2'h1: wrap_ready = POWER_MODE.slow_mode
                               ? &state_reg.count[14:0]
                               : &state_reg.count[22:0];
            2'h2: wrap_ready = POWER_MODE.slow_mode
                               ? &state_reg.count[12:0]
                               : &state_reg.count[20:0];
            default: wrap_ready = POWER_MODE.slow_mode
                                  ? &state_reg.count[10:0]
                                  : &state_reg.count[18:0];
        endcase
    end

    assign trap_hit = FETCH_VALID && FETCH_ADDR >= `TRAP_LOW
                      && FETCH_ADDR <= `TRAP_HIGH;
    assign clock_stop = !SYSTEM_CONTROL_TWO[`HIGH_OSC_BIT]
                        && !SYSTEM_CONTROL_TWO[`LOW_OSC_BIT];

    always_comb begin
        state_next = state_reg;
        state_next.int_out = 1'b0;

        // Write-only: no read path exists, so read-modify-write is moot
        if (wr_one) begin
            state_next.control_one[`ENABLE_BIT] = wdata[`ENABLE_BIT];
            state_next.control_one[`TIME_MSB:`TIME_LSB] =
                wdata[`TIME_MSB:`TIME_LSB];
            if (!wdata[`ACTION_BIT] && !state_reg.action_locked) begin
                state_next.control_one[`ACTION_BIT] = 1'b0;
            end
            state_next.action_locked = 1'b1;
            if (wdata[`ENABLE_BIT]) begin
                state_next.disabled = 1'b0;
            end
        end

        if (wr_two) begin
            if (wdata == `CODE_CLEAR) begin
                state_next.count = '0;
            end else if (wdata == `CODE_DISABLE
                         && !state_reg.control_one[`ENABLE_BIT]) begin
                state_next.disabled = 1'b1;
            end
        end

        state_next.wrapped = 1'b0;
        if (state_next.disabled) begin
            state_next.count = '0;
        end else if (!(wr_two && wdata == `CODE_CLEAR)
                     && !POWER_MODE.stop_mode && !POWER_MODE.idle_mode
                     && tick) begin
            state_next.count = state_reg.count + 25'h0000001;
            state_next.wrapped = wrap_ready;
        end

        // A clear landing on the carry cycle suppresses the event
        if (state_reg.wrapped) begin
            if (state_reg.control_one[`ACTION_BIT]) begin
                state_next.pin_drive = 1'b1;
                state_next.pulse_count = `PULSE_WIDTH'(`RESET_CYCLES);
                state_next.cause = SRC_WATCHDOG;
                if (POWER_MODE.slow_mode) begin
                    state_next.osc_req = 1'b1;
                end
            end else begin
                state_next.nmi_pending = 1'b1;
            end
        end

        // Not gated by any enable register; held while one is in service
        if (RETURN_FROM_NMI) begin
            state_next.nmi_in_service = 1'b0;
        end
        if (state_next.nmi_pending && !state_reg.nmi_in_service
            && !RETURN_FROM_NMI) begin
            state_next.int_out = 1'b1;
            state_next.nmi_pending = 1'b0;
            state_next.nmi_in_service = 1'b1;
        end

        if (trap_hit && !state_reg.pin_drive) begin
            state_next.pin_drive = 1'b1;
            state_next.pulse_count = `PULSE_WIDTH'(`RESET_CYCLES);
            state_next.cause = SRC_TRAP;
        end
        if (clock_stop && !state_reg.pin_drive) begin
            state_next.pin_drive = 1'b1;
            state_next.pulse_count = `PULSE_WIDTH'(`RESET_CYCLES);
            state_next.cause = SRC_CLOCK;
        end

        if (state_reg.pin_drive) begin
            if (state_reg.pulse_count <= `PULSE_WIDTH'(1)) begin
                state_next.pin_drive = 1'b0;
            end else begin
                state_next.pulse_count = state_reg.pulse_count
                                         - `PULSE_WIDTH'(1);
            end
        end

        // Pin low long enough counts as reset; shorter glitches are ignored.
        // The twelfth low cycle already counts, so our own 12-cycle pulse
        // resets the core as well.
        if (!RESET_PIN_IN) begin
            if (state_reg.ext_low_count
                < `PULSE_WIDTH'(`EXT_MIN_CYCLES - 1)) begin
                state_next.ext_low_count = state_reg.ext_low_count
                                           + `PULSE_WIDTH'(1);
            end else begin
                state_next.sys_reset = 1'b1;
            end
        end else begin
            state_next.ext_low_count = '0;
            state_next.sys_reset = 1'b0;
        end

        if (state_next.sys_reset) begin
            state_next.control_one = `CONTROL_ONE_RESET;
            state_next.action_locked = 1'b0;
            state_next.disabled = 1'b0;
            state_next.count = '0;
            state_next.wrapped = 1'b0;
            state_next.nmi_pending = 1'b0;
            state_next.nmi_in_service = 1'b0;
            state_next.int_out = 1'b0;
        end
        if (state_next.sys_reset && !state_reg.sys_reset
            && state_reg.pin_drive == 1'b0 && !state_next.pin_drive) begin
            state_next.cause = SRC_NONE;
        end
        if (!state_next.sys_reset && state_reg.sys_reset) begin
            state_next.osc_req = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_reg <= '{control_one: `CONTROL_ONE_RESET,
                           vector: `VECTOR_LOW,
                           cause: SRC_NONE, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Open drain: only the enable ever moves
    assign RESET_PIN_OUT      = state_reg.pin_out;
    assign RESET_PIN_OE       = state_reg.pin_drive;
    assign WATCHDOG_INTERRUPT = state_reg.int_out;
    assign SYSTEM_RESET       = state_reg.sys_reset;
    assign HIGH_OSC_ON_REQ    = state_reg.osc_req;
    assign VECTOR_ADDR        = state_reg.vector;
    assign RESET_CAUSE        = state_reg.cause;
endmodule : wdt_reset_top

// ### tb/wdt_reset_props.sv
// Port assertions for the watchdog and reset source block
`timescale 1ns/100ps
module wdt_reset_props (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        FETCH_VALID,
    input wire logic [15:0] FETCH_ADDR,
    input wire logic [7:0]  SYSTEM_CONTROL_TWO,
    input wire logic        RESET_PIN_IN,
    input wire logic        RESET_PIN_OUT,
    input wire logic        RESET_PIN_OE,
    input wire logic        WATCHDOG_INTERRUPT,
    input wire logic        SYSTEM_RESET,
    input wire logic [15:0] VECTOR_ADDR
);
    typedef struct packed {
        logic [3:0] oe_cnt;
        logic [3:0] low_cnt;
    } count_t;
    count_t cnt_reg;
    count_t cnt_next;
    // Saturate so a stuck pin cannot wrap back into range
    always_comb begin
        cnt_next = cnt_reg;
        if (!RESET_PIN_OE)
            cnt_next.oe_cnt = 4'h0;
        else if (cnt_reg.oe_cnt != 4'hF)
            cnt_next.oe_cnt = cnt_reg.oe_cnt + 4'h1;
        if (RESET_PIN_IN)
            cnt_next.low_cnt = 4'h0;
        else if (cnt_reg.low_cnt != 4'hF)
            cnt_next.low_cnt = cnt_reg.low_cnt + 4'h1;
    end
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    chk_pin_width: assert property (
        $fell(RESET_PIN_OE) |-> cnt_reg.oe_cnt == 4'hC) else $error("pulse");
    chk_pin_bound: assert property (
        cnt_reg.oe_cnt <= 4'hC) else $error("pulse long");
    chk_pin_drain: assert property (
        RESET_PIN_OUT == 1'b0) else $error("pin level");
    chk_trap_fetch: assert property (
        FETCH_VALID && FETCH_ADDR >= 16'h0040 && FETCH_ADDR <= 16'h023F
        && !RESET_PIN_OE && !SYSTEM_RESET |-> ##[1:3] RESET_PIN_OE)
        else $error("trap");
    chk_clock_stop: assert property (
        SYSTEM_CONTROL_TWO[7:6] == 2'b00 && !RESET_PIN_OE && !SYSTEM_RESET
        |-> ##[1:3] RESET_PIN_OE) else $error("clock stop");
    chk_irq_pulse: assert property (
        WATCHDOG_INTERRUPT |=> !WATCHDOG_INTERRUPT) else $error("irq");
    chk_irq_or_pin: assert property (
        WATCHDOG_INTERRUPT |-> !RESET_PIN_OE) else $error("irq and pin");
    chk_ext_reset: assert property (
        cnt_reg.low_cnt >= 4'hC |-> SYSTEM_RESET) else $error("ext");
    chk_vector_addr: assert property (
        VECTOR_ADDR == 16'hFFFE) else $error("vector");
    cover property ($rose(RESET_PIN_OE));
    cover property (WATCHDOG_INTERRUPT);
    cover property ($rose(SYSTEM_RESET));
endmodule : wdt_reset_props

// ### tb/wdt_reset_partner.sv
// Reset pin with pull-up and an external reset circuit
`timescale 1ns/100ps
module wdt_reset_partner (
    input  wire logic CLOCK,
    input  wire logic ext_req,
    input  wire logic pin_oe,
    input  wire logic pin_out,
    output logic      pin_level
);
    logic [4:0] hold_reg = 5'h00;
    // Held 20 cycles, well past the minimum
    always_ff @(posedge CLOCK)
        hold_reg <= ext_req ? 5'h14
                    : hold_reg - {4'h0, hold_reg != 5'h00};
    assign pin_level = !(pin_oe && !pin_out) && hold_reg == 5'h00;
endmodule : wdt_reset_partner

// ### tb/wdt_reset_top_tb_top.sv
// Self-checking bench for the watchdog and reset source block
`timescale 1ns/100ps
module wdt_reset_top_tb_top;
    import wdt_reset_pkg::*;
    logic CLOCK = 1'b0, RST = 1'b1, FETCH_VALID = 1'b0, ext_req = 1'b0;
    logic RETURN_FROM_NMI = 1'b0, hit;
    logic [15:0] FETCH_ADDR = 16'h0000;
    logic [7:0] SYSTEM_CONTROL_TWO = 8'hC0;
    reg_write_t REG_WRITE = '0;
    // Slow mode with fs every cycle keeps overflows near 2048 cycles at code 11
    power_mode_t POWER_MODE = 4'h3;
    logic RESET_PIN_IN, RESET_PIN_OUT, RESET_PIN_OE, WATCHDOG_INTERRUPT;
    logic SYSTEM_RESET, HIGH_OSC_ON_REQ;
    logic [15:0] VECTOR_ADDR;
    logic [1:0] RESET_CAUSE;
    int checks = 0, bad_count = 0;
    logic [15:0] taddr [4] = '{16'h003F, 16'h0040, 16'h023F, 16'h0240};
    logic [7:0] sctl [3] = '{8'h40, 8'h80, 8'h00};
    wdt_reset_top wdt_reset_top_i (.CLOCK, .RST, .REG_WRITE, .POWER_MODE,
        .FETCH_VALID, .FETCH_ADDR, .SYSTEM_CONTROL_TWO, .RETURN_FROM_NMI,
        .RESET_PIN_IN, .RESET_PIN_OUT, .RESET_PIN_OE, .WATCHDOG_INTERRUPT,
        .SYSTEM_RESET, .HIGH_OSC_ON_REQ, .VECTOR_ADDR, .RESET_CAUSE);
    wdt_reset_partner wdt_reset_partner_i (.CLOCK, .ext_req,
        .pin_oe(RESET_PIN_OE), .pin_out(RESET_PIN_OUT),
        .pin_level(RESET_PIN_IN));
    initial forever #25 CLOCK = ~CLOCK;
    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic restart();
        RST = 1'b1;
        tick(16);
        RST = 1'b0;
        tick(2);
    endtask : restart
    // Gap cycle after each write so the strobe is never raised twice at once
    task automatic wr(input logic [7:0] a, d);
        REG_WRITE = '{1'b1, a, d};
        tick(1);
        REG_WRITE.write_strobe = 1'b0;
        tick(1);
    endtask : wr
    task automatic expect_ev(input int n, input logic irq, exp,
                             input string what);
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++) begin
            tick(1);
            hit = (irq ? WATCHDOG_INTERRUPT : RESET_PIN_OE) === 1'b1;
        end
        check(what, hit, exp);
    endtask : expect_ev
    task automatic probe(input logic [1:0] cause);
        expect_ev(4, 1'b0, cause != 2'h0, "pin");
        if (hit) begin
            tick(2);
            check("cause", RESET_CAUSE, cause);
            tick(20);
        end
    endtask : probe
    initial begin
        restart();
        check("vector", VECTOR_ADDR, 16'hFFFE);
        check("cause0", RESET_CAUSE, 2'h0);
        foreach (taddr[i]) begin
            FETCH_ADDR = taddr[i];
            FETCH_VALID = 1'b1;
            tick(1);
            FETCH_VALID = 1'b0;
            probe((i == 1 || i == 2) ? 2'h2 : 2'h0);
        end
        foreach (sctl[i]) begin
            SYSTEM_CONTROL_TWO = sctl[i];
            tick(1);
            SYSTEM_CONTROL_TWO = 8'hC0;
            probe(i == 2 ? 2'h3 : 2'h0);
        end
        ext_req = 1'b1;
        tick(1);
        ext_req = 1'b0;
        tick(17);
        check("ext", SYSTEM_RESET, 1'b1);
        tick(6);
        check("ext off", SYSTEM_RESET, 1'b0);
        $display("test reset sources done");
        restart();
        wr(8'h34, 8'h0F);
        wr(8'h35, 8'h4E);
        expect_ev(1500, 1'b0, 1'b0, "clear");
        wr(8'h35, 8'h4E);
        expect_ev(1500, 1'b0, 1'b0, "restart");
        POWER_MODE = 4'hB;
        expect_ev(1500, 1'b0, 1'b0, "stop");
        POWER_MODE = 4'h7;
        expect_ev(1500, 1'b0, 1'b0, "idle");
        POWER_MODE = 4'h2;
        expect_ev(1500, 1'b0, 1'b0, "fs quiet");
        POWER_MODE = 4'h3;
        expect_ev(700, 1'b0, 1'b1, "resume");
        tick(2);
        check("wd cause", RESET_CAUSE, 2'h1);
        check("osc", HIGH_OSC_ON_REQ, 1'b1);
        $display("test watchdog reset done");
        restart();
        wr(8'h34, 8'h0E);
        wr(8'h34, 8'h0F);
        wr(8'h35, 8'h4E);
        expect_ev(2100, 1'b1, 1'b1, "irq");
        check("no pin", RESET_PIN_OE, 1'b0);
        check("no osc", HIGH_OSC_ON_REQ, 1'b0);
        expect_ev(2200, 1'b1, 1'b0, "held");
        RETURN_FROM_NMI = 1'b1;
        tick(1);
        RETURN_FROM_NMI = 1'b0;
        expect_ev(4, 1'b1, 1'b1, "freed");
        $display("test interrupt done");
        restart();
        wr(8'h34, 8'h0F);
        wr(8'h35, 8'h4E);
        expect_ev(1500, 1'b0, 1'b0, "run");
        wr(8'h35, 8'hB1);
        wr(8'h35, 8'h12);
        expect_ev(700, 1'b0, 1'b1, "codes");
        restart();
        wr(8'h34, 8'h0F);
        wr(8'h35, 8'h4E);
        expect_ev(1500, 1'b0, 1'b0, "run2");
        wr(8'h34, 8'h07);
        wr(8'h35, 8'hB1);
        POWER_MODE = 4'hB;
        tick(100);
        POWER_MODE = 4'h3;
        expect_ev(3000, 1'b0, 1'b0, "off");
        wr(8'h34, 8'h0F);
        expect_ev(1900, 1'b0, 1'b0, "zeroed");
        expect_ev(200, 1'b0, 1'b1, "on");
        $display("test disable done");
        restart();
        wr(8'h34, 8'h0D);
        wr(8'h35, 8'h4E);
        expect_ev(8150, 1'b0, 1'b0, "code 10 early");
        expect_ev(100, 1'b0, 1'b1, "code 10");
        $display("test detection time done");
        tally_and_finish();
    end
    initial begin
        tick(60000);
        bad_count++;
        tally_and_finish();
    end
endmodule : wdt_reset_top_tb_top
bind wdt_reset_top wdt_reset_props wdt_reset_props_i (.CLOCK, .RST,
    .FETCH_VALID, .FETCH_ADDR, .SYSTEM_CONTROL_TWO, .RESET_PIN_IN,
    .RESET_PIN_OUT, .RESET_PIN_OE, .WATCHDOG_INTERRUPT, .SYSTEM_RESET,
    .VECTOR_ADDR);
